//--- src/agcr_regs.sv
// Gain, automatic gain, identification and configuration register bank
`timescale 1ns/10ps
`include "agcr_map.svh"

module agcr_regs
   import agcr_pkg::*;
#(
   parameter int unsigned NUM_MOD = `AGCR_NUM_MOD,
   // Identification values: arbitrary neutral codes
   parameter logic [7:0]  AUX_ID  = 8'h5A,
   parameter logic [7:0]  REV_ID  = 8'hA5,
   parameter logic [7:0]  DEV_ID  = 8'h3C
) (
   input  wire  logic               clk_sys_i,
   input  wire  logic               rst_n_i,
   input  wire  agcr_req_t          reg_req_i,
   input  wire  logic [NUM_MOD-1:0] meas_done_i,
   input  wire  logic [NUM_MOD-1:0] sat_i,
   input  wire  logic [NUM_MOD-1:0] low_sig_i,
   input  wire  logic               func_idle_i,
   output logic       [7:0]         rd_data_o,
   output logic                     rd_valid_o,
   output logic       [3:0]         mod6_gain_o,
   output logic       [3:0]         mod7_gain_o,
   output logic       [NUM_MOD-1:0] auto_gain_en_o,
   output logic       [NUM_MOD-1:0] agc_up_o,
   output logic       [NUM_MOD-1:0] agc_dn_o,
   output logic                     idle_power_saving_o,
   output agcr_bank_t               bank_sel_o
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic       [3:0]         gain6_r;
   logic       [3:0]         gain6_nxt;
   logic       [3:0]         gain7_r;
   logic       [3:0]         gain7_nxt;
   logic       [NUM_MOD-1:0] agc_en_r;
   logic                     idle_en_r;
   logic       [2:0]         bank_r;
   logic       [7:0]         rd_data_r;
   logic                     rd_valid_r;
   logic       [NUM_MOD-1:0] up_r;
   logic       [NUM_MOD-1:0] dn_r;
   logic                     low_power_r;
   agcr_bank_t               bank_sel_r;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic wr_gain67;
   logic wr_agc_en;
   logic wr_general_config_zero;

   assign wr_gain67 = reg_req_i.wr
                    && (reg_req_i.addr == `AGCR_ADDR_GAIN67);
   assign wr_agc_en = reg_req_i.wr
                    && (reg_req_i.addr == `AGCR_ADDR_AGC_EN);
   assign wr_general_config_zero   = reg_req_i.wr
                    && (reg_req_i.addr == `AGCR_ADDR_GENERAL_CONFIG_ZERO);

   // ------------------------------------------------------------
   // Automatic gain decisions per modulator
   // ------------------------------------------------------------
   logic [NUM_MOD-1:0] at_top;
   logic [NUM_MOD-1:0] at_bot;
   logic [NUM_MOD-1:0] up_want;
   logic [NUM_MOD-1:0] dn_want;

   for (genvar g = 0; g < NUM_MOD; g++) begin : g_agc
      // Only six and seven keep their gain here; others clamp outside
      if (g == 6) begin : g_six
         assign at_top[g] = (gain6_r >= `AGCR_GAIN_MAX);
         assign at_bot[g] = (gain6_r == `AGCR_GAIN_MIN);
      end else if (g == 7) begin : g_seven
         assign at_top[g] = (gain7_r >= `AGCR_GAIN_MAX);
         assign at_bot[g] = (gain7_r == `AGCR_GAIN_MIN);
      end else begin : g_ext
         assign at_top[g] = 1'b0;
         assign at_bot[g] = 1'b0;
      end
      // RL4 saturation lowers gain
      assign dn_want[g] = agc_en_r[g] && meas_done_i[g]
                        && sat_i[g] && !at_bot[g];
      // RL4 headroom raises gain
      assign up_want[g] = agc_en_r[g] && meas_done_i[g]
                        && !sat_i[g] && low_sig_i[g]
                        && !at_top[g];
   end

   // ------------------------------------------------------------
   // Next gain values
   // ------------------------------------------------------------
   // Host write takes priority over an automatic step
   always_comb begin
      gain6_nxt = gain6_r;
      if (wr_gain67) begin
         // RL2 modulator six field
         gain6_nxt = reg_req_i.wdata[`AGCR_GAIN6_MSB:`AGCR_GAIN6_LSB];
      end else if (dn_want[6]) begin
         // RL4 step six down
         gain6_nxt = gain6_r - 4'h1;
      end else if (up_want[6]) begin
         // RL4 step six up
         gain6_nxt = gain6_r + 4'h1;
      end
   end

   always_comb begin
      gain7_nxt = gain7_r;
      if (wr_gain67) begin
         // RL1 modulator seven field
         gain7_nxt = reg_req_i.wdata[`AGCR_GAIN7_MSB:`AGCR_GAIN7_LSB];
      end else if (dn_want[7]) begin
         // RL4 step seven down
         gain7_nxt = gain7_r - 4'h1;
      end else if (up_want[7]) begin
         // RL4 step seven up
         gain7_nxt = gain7_r + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Modulator six gain field
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         gain6_r <= `AGCR_GAIN_RST;
      end else begin
         gain6_r <= gain6_nxt;
      end
   end

   // ------------------------------------------------------------
   // Modulator seven gain field
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         gain7_r <= `AGCR_GAIN_RST;
      end else begin
         gain7_r <= gain7_nxt;
      end
   end

   // ------------------------------------------------------------
   // Automatic gain enable register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         agc_en_r <= NUM_MOD'(`AGCR_AGC_EN_RST);
      end else if (wr_agc_en) begin
         // RL3 one bit per modulator
         agc_en_r <= NUM_MOD'(reg_req_i.wdata);
      end
   end

   // ------------------------------------------------------------
   // Configuration register zero
   // ------------------------------------------------------------
   // Reserved bits are not stored and read back their reset value
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         idle_en_r <= 1'(`AGCR_GENERAL_CONFIG_ZERO_RST >> `AGCR_GENERAL_CONFIG_ZERO_IDLE_BIT);
      end else if (wr_general_config_zero) begin
         // RL7 idle power saving enable
         idle_en_r <= reg_req_i.wdata[`AGCR_GENERAL_CONFIG_ZERO_IDLE_BIT];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         bank_r <= `AGCR_BANK_RST;
      end else if (wr_general_config_zero) begin
         // RL8 bank select field
         bank_r <= reg_req_i.wdata[`AGCR_GENERAL_CONFIG_ZERO_BANK_MSB:
                                   `AGCR_GENERAL_CONFIG_ZERO_BANK_LSB];
      end
   end

   // ------------------------------------------------------------
   // Read multiplexer
   // ------------------------------------------------------------
   logic [7:0] general_config_zero_val;
   logic [7:0] rd_mux;

   always_comb begin
      general_config_zero_val = `AGCR_GENERAL_CONFIG_ZERO_RST;
      general_config_zero_val[`AGCR_GENERAL_CONFIG_ZERO_IDLE_BIT] = idle_en_r;
      general_config_zero_val[`AGCR_GENERAL_CONFIG_ZERO_BANK_MSB:`AGCR_GENERAL_CONFIG_ZERO_BANK_LSB] = bank_r;
   end

   always_comb begin
      case (reg_req_i.addr)
         `AGCR_ADDR_GAIN67: begin
            rd_mux = {gain7_r, gain6_r};
         end
         `AGCR_ADDR_AGC_EN: begin
            rd_mux = 8'(agc_en_r);
         end
         // RL5 RL6 fixed codes, no write path
         `AGCR_ADDR_AUX_ID: begin
            rd_mux = AUX_ID;
         end
         `AGCR_ADDR_REV_ID: begin
            rd_mux = REV_ID;
         end
         `AGCR_ADDR_DEV_ID: begin
            rd_mux = DEV_ID;
         end
         `AGCR_ADDR_GENERAL_CONFIG_ZERO: begin
            rd_mux = general_config_zero_val;
         end
         default: begin
            rd_mux = `AGCR_UNMAPPED_RD;
         end
      endcase
   end

   // RL6 identification writes have no decode, so nothing changes

   // ------------------------------------------------------------
   // Read answer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rd_data_r  <= `AGCR_UNMAPPED_RD;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= reg_req_i.rd;
         if (reg_req_i.rd) begin
            rd_data_r <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // Step pulses to the modulator gain stages
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         up_r <= '0;
         dn_r <= '0;
      end else begin
         // RL4 pulses on a taken step
         up_r <= up_want & ~dn_want;
         dn_r <= dn_want;
         // Host write to six/seven cancels their step
         if (wr_gain67) begin
            up_r[7:6] <= 2'h0;
            dn_r[7:6] <= 2'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // Low power idle
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         low_power_r <= 1'b0;
      end else begin
         // RL7 all functions waiting or off
         low_power_r <= idle_en_r && func_idle_i;
      end
   end

   // ------------------------------------------------------------
   // Bank decode
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         bank_sel_r <= AGCR_BANK_ZERO;
      end else begin
         // RL8 bank code to target
         case (bank_r)
            3'h0: begin
               bank_sel_r <= AGCR_BANK_ZERO;
            end
            3'h1: begin
               bank_sel_r <= AGCR_BANK_FOUR;
            end
            3'h3: begin
               bank_sel_r <= AGCR_BANK_FLICKER;
            end
            default: begin
               bank_sel_r <= AGCR_BANK_REMOTE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rd_data_o           = rd_data_r;
   assign rd_valid_o          = rd_valid_r;
   assign mod6_gain_o         = gain6_r;
   assign mod7_gain_o         = gain7_r;
   assign auto_gain_en_o      = agc_en_r;
   assign agc_up_o            = up_r;
   assign agc_dn_o            = dn_r;
   assign idle_power_saving_o = low_power_r;
   assign bank_sel_o          = bank_sel_r;

endmodule : agcr_regs

//--- src/agcr_map.svh
// Register map, field positions, reset values and counts for the bank
// Behaviour
// RL1 - Bits 7:4 of the gain register for modulators six and seven hold modulator seven's gain code, reset 0000, read/write, code n meaning gain 2^(n+1) for n up to 11 and codes 12 to 15 reserved.
// RL2 - Bits 3:0 of the same register hold modulator six's gain code with the same encoding and reset 0000, read/write.
// RL3 - The automatic gain enable register has one read/write bit per modulator, bit n for modulator n, all resetting to zero.
// RL4 - A modulator whose automatic gain bit is set has its gain stepped by the device toward the largest signal that does not saturate.
// RL5 - Three fixed 8-bit identification registers sit at 0x90, 0x91 and 0x92 for the auxiliary, revision and device codes.
// RL6 - Host writes to the identification registers leave them unchanged.
// RL7 - With the idle power saving bit 6 of configuration register zero set, the device drops to low power whenever every function is waiting or disabled.
// RL8 - The bank field in bits 2:0 of configuration register zero, reset 000, steers low-address accesses to bank 0, bank 4, flicker data or remote control.
// RL9 - The host writes the reserved configuration bits with their reset values and avoids reserved gain codes.
`ifndef AGCR_MAP_SVH
`define AGCR_MAP_SVH

`define AGCR_ADDR_GAIN67   8'h8C
`define AGCR_ADDR_AGC_EN   8'h8D
`define AGCR_ADDR_AUX_ID   8'h90
`define AGCR_ADDR_REV_ID   8'h91
`define AGCR_ADDR_DEV_ID   8'h92
`define AGCR_ADDR_GENERAL_CONFIG_ZERO     8'h93

`define AGCR_GAIN7_MSB     7
`define AGCR_GAIN7_LSB     4
`define AGCR_GAIN6_MSB     3
`define AGCR_GAIN6_LSB     0
`define AGCR_GENERAL_CONFIG_ZERO_IDLE_BIT 6
`define AGCR_GENERAL_CONFIG_ZERO_BANK_MSB 2
`define AGCR_GENERAL_CONFIG_ZERO_BANK_LSB 0

`define AGCR_GAIN_RST      4'h0
`define AGCR_GAIN_MAX      4'hB
`define AGCR_GAIN_MIN      4'h0
`define AGCR_AGC_EN_RST    8'h00
`define AGCR_GENERAL_CONFIG_ZERO_RST      8'h20
`define AGCR_BANK_RST      3'h0
`define AGCR_UNMAPPED_RD   8'h00

`define AGCR_NUM_MOD       8
`define AGCR_RD_LATENCY    1

`endif

//--- src/agcr_pkg.sv
// Types shared by the configuration bank and its users
package agcr_pkg;

   // Host register access, one request per cycle
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } agcr_req_t;

   // Target of low-address accesses
   typedef enum logic [1:0] {
      AGCR_BANK_ZERO,
      AGCR_BANK_FOUR,
      AGCR_BANK_FLICKER,
      AGCR_BANK_REMOTE
   } agcr_bank_t;

endpackage : agcr_pkg

//--- verif/agcr_regs_checker.sv
// Port assertions for the configuration bank
`timescale 1ns/10ps
module agcr_regs_checker
   import agcr_pkg::*;
#(
   parameter int unsigned NUM_MOD = 8,
   parameter logic [7:0]  AUX_ID  = 8'h00,
   parameter logic [7:0]  DEV_ID  = 8'h00
) (
   input wire logic               clk_sys_i,
   input wire logic               rst_n_i,
   input wire agcr_req_t          reg_req_i,
   input wire logic [NUM_MOD-1:0] meas_done_i,
   input wire logic [NUM_MOD-1:0] sat_i,
   input wire logic               func_idle_i,
   input wire logic [7:0]         rd_data_o,
   input wire logic               rd_valid_o,
   input wire logic [3:0]         mod6_gain_o,
   input wire logic [3:0]         mod7_gain_o,
   input wire logic [NUM_MOD-1:0] auto_gain_en_o,
   input wire logic [NUM_MOD-1:0] agc_up_o,
   input wire logic [NUM_MOD-1:0] agc_dn_o,
   input wire logic               idle_power_saving_o,
   input wire agcr_bank_t         bank_sel_o
);
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   logic w_gain;
   assign w_gain = reg_req_i.wr && reg_req_i.addr == 8'h8C;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_rd_ans; reg_req_i.rd |=> rd_valid_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
   property p_rd_none; !reg_req_i.rd |=> !rd_valid_o; endproperty
   a_rd_none: assert property (p_rd_none) else $error("stray valid");
   property p_aux; reg_req_i.rd && reg_req_i.addr == 8'h90
      |=> rd_data_o == AUX_ID; endproperty
   a_aux: assert property (p_aux) else $error("aux id wrong");
   property p_dev; reg_req_i.rd && reg_req_i.addr == 8'h92
      |=> rd_data_o == DEV_ID; endproperty
   a_dev: assert property (p_dev) else $error("device id wrong");
   property p_gain; w_gain |=> {mod7_gain_o, mod6_gain_o}
      == $past(reg_req_i.wdata); endproperty
   a_gain: assert property (p_gain) else $error("gain not written");
   property p_agc_en; reg_req_i.wr && reg_req_i.addr == 8'h8D
      |=> auto_gain_en_o == $past(reg_req_i.wdata); endproperty
   a_agc_en: assert property (p_agc_en) else $error("enable lost");
   property p_dn6; meas_done_i[6] && auto_gain_en_o[6] && sat_i[6]
      && mod6_gain_o != 4'h0 && !w_gain
      |=> agc_dn_o[6] && mod6_gain_o == $past(mod6_gain_o) - 4'h1;
   endproperty
   a_dn6: assert property (p_dn6) else $error("no step down");
   property p_quiet; meas_done_i == '0 |=> (agc_up_o | agc_dn_o) == '0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("stray step");
   property p_idle; !func_idle_i |=> !idle_power_saving_o; endproperty
   a_idle: assert property (p_idle) else $error("idle while busy");
   property p_bank; reg_req_i.wr && reg_req_i.addr == 8'h93
      && reg_req_i.wdata[2:0] == 3'h3 |=> ##1 bank_sel_o == AGCR_BANK_FLICKER;
   endproperty
   a_bank: assert property (p_bank) else $error("bank wrong");
   c_dn6: cover property (agc_dn_o[6]);
   c_up: cover property (agc_up_o != '0);
   c_idle: cover property (idle_power_saving_o);
   c_bank: cover property (bank_sel_o == AGCR_BANK_FLICKER);
endmodule : agcr_regs_checker

bind agcr_regs agcr_regs_checker #(.NUM_MOD(NUM_MOD), .AUX_ID(AUX_ID),
   .DEV_ID(DEV_ID)) u_chk (.clk_sys_i, .rst_n_i, .reg_req_i, .meas_done_i,
   .sat_i, .func_idle_i, .rd_data_o, .rd_valid_o, .mod6_gain_o, .mod7_gain_o,
   .auto_gain_en_o, .agc_up_o, .agc_dn_o, .idle_power_saving_o, .bank_sel_o);

//--- verif/agcr_host_model.sv
// Host side model issuing register accesses
`timescale 1ns/10ps
module agcr_host_model
   import agcr_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i,
   output agcr_req_t       req_o
);
   // ---------------------------------------------
   // Accesses, released bus shows inverted values
   // ---------------------------------------------
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h93) v = {1'b0, d[6], 3'b100, d[2:0]};
      @(posedge clk_sys_i);
      req_o <= {2'b10, a, v};
      @(posedge clk_sys_i);
      req_o <= {2'b00, ~a, ~v};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge clk_sys_i);
      req_o <= {2'b01, a, 8'h00};
      @(posedge clk_sys_i);
      req_o <= {2'b00, ~a, 8'hFF};
      #1;
      ok = rd_valid_i;
      d = rd_data_i;
   endtask : rd
endmodule : agcr_host_model

//--- verif/agcr_regs_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
module agcr_regs_tb
   import agcr_pkg::*;
;
   // ---------------------------------------------
   // Bench
   // ---------------------------------------------
   logic       clk_sys_i, rst_n_i, func_idle_i, rd_valid_o, ok;
   logic       idle_power_saving_o;
   logic [7:0] meas_done_i, sat_i, low_sig_i, auto_gain_en_o, agc_up_o;
   logic [7:0] agc_dn_o, rd_data_o, d;
   logic [3:0] mod6_gain_o, mod7_gain_o;
   agcr_req_t  reg_req_i;
   agcr_bank_t bank_sel_o;
   agcr_bank_t eb;
   int         n_errors, comparisons, cyc;
   logic [7:0] ra [7] = '{8'h8C, 8'h8D, 8'h90, 8'h91, 8'h92, 8'h93, 8'h50};
   logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h5A, 8'hA5, 8'h3C, 8'h20, 8'h00};

   agcr_regs #(.AUX_ID(8'h5A), .REV_ID(8'hA5), .DEV_ID(8'h3C)) uut (
      .clk_sys_i, .rst_n_i, .reg_req_i, .meas_done_i, .sat_i, .low_sig_i,
      .func_idle_i, .rd_data_o, .rd_valid_o, .mod6_gain_o, .mod7_gain_o,
      .auto_gain_en_o, .agc_up_o, .agc_dn_o, .idle_power_saving_o,
      .bank_sel_o);
   agcr_host_model host (.clk_sys_i, .rd_data_i(rd_data_o),
      .rd_valid_i(rd_valid_o), .req_o(reg_req_i));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, d, ok);
      chk8({7'h0, ok}, 8'h01);
      chk8(d, exp);
   endtask : rdchk
   task automatic automatic_gain_control(input int n, input logic s, input logic l,
                      input logic [7:0] up, input logic [7:0] dn);
      @(posedge clk_sys_i);
      meas_done_i[n] <= 1'b1;
      sat_i[n] <= s;
      low_sig_i[n] <= l;
      @(posedge clk_sys_i);
      meas_done_i <= '0;
      sat_i <= '0;
      low_sig_i <= '0;
      #1;
      chk8(agc_up_o, up);
      chk8(agc_dn_o, dn);
   endtask : automatic_gain_control
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      rst_n_i = 1'b0;
      func_idle_i = 1'b0;
      meas_done_i = '0;
      sat_i = '0;
      low_sig_i = '0;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 7; i++) rdchk(ra[i], rv[i]);
      $display("reset values done");
      host.wr(8'h8C, 8'h5B);
      #1 chk8({mod7_gain_o, mod6_gain_o}, 8'h5B);
      rdchk(8'h8C, 8'h5B);
      host.wr(8'h8D, 8'hA5);
      #1 chk8(auto_gain_en_o, 8'hA5);
      for (int i = 2; i < 5; i++) host.wr(ra[i], 8'hFF);
      for (int i = 2; i < 5; i++) rdchk(ra[i], rv[i]);
      $display("read write done");
      for (int b = 0; b < 8; b++) begin
         host.wr(8'h93, {5'b01100, b[2:0]});
         @(posedge clk_sys_i);
         eb = (b == 0) ? AGCR_BANK_ZERO : (b == 1) ? AGCR_BANK_FOUR :
              (b == 3) ? AGCR_BANK_FLICKER : AGCR_BANK_REMOTE;
         #1 chk8({6'h0, bank_sel_o}, {6'h0, eb});
      end
      rdchk(8'h93, 8'h67);
      @(posedge clk_sys_i) func_idle_i <= 1'b1;
      @(posedge clk_sys_i) #1 chk8({7'h0, idle_power_saving_o}, 8'h01);
      @(posedge clk_sys_i) func_idle_i <= 1'b0;
      @(posedge clk_sys_i) #1 chk8({7'h0, idle_power_saving_o}, 8'h00);
      host.wr(8'h93, 8'h07);
      @(posedge clk_sys_i) func_idle_i <= 1'b1;
      @(posedge clk_sys_i) #1 chk8({7'h0, idle_power_saving_o}, 8'h00);
      @(posedge clk_sys_i) func_idle_i <= 1'b0;
      $display("config done");
      host.wr(8'h8D, 8'hC1);
      host.wr(8'h8C, 8'hB3);
      automatic_gain_control(6, 1'b1, 1'b0, 8'h00, 8'h40);
      chk8({4'h0, mod6_gain_o}, 8'h02);
      automatic_gain_control(7, 1'b0, 1'b1, 8'h00, 8'h00);
      automatic_gain_control(0, 1'b0, 1'b1, 8'h01, 8'h00);
      automatic_gain_control(1, 1'b0, 1'b1, 8'h00, 8'h00);
      automatic_gain_control(7, 1'b1, 1'b0, 8'h00, 8'h80);
      chk8({mod7_gain_o, mod6_gain_o}, 8'hA2);
      automatic_gain_control(6, 1'b0, 1'b1, 8'h40, 8'h00);
      chk8({4'h0, mod6_gain_o}, 8'h03);
      $display("automatic gain done");
      @(posedge clk_sys_i) rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      #1 chk8({mod7_gain_o, mod6_gain_o}, 8'h00);
      chk8(auto_gain_en_o, 8'h00);
      chk8({6'h0, bank_sel_o}, {6'h0, AGCR_BANK_ZERO});
      rdchk(8'h93, 8'h20);
      $display("mid-run reset done");
      print_verdict();
   end
endmodule : agcr_regs_tb
